/* hdl/nor_host_pkg.sv */
package nor_host_pkg;

    // user operations
    localparam logic [3:0] OP_READ        = 4'h0;
    localparam logic [3:0] OP_PROGRAM     = 4'h1;
    localparam logic [3:0] OP_ENTER_SEC   = 4'h2;
    localparam logic [3:0] OP_EXIT_SEC    = 4'h3;
    localparam logic [3:0] OP_QUERY       = 4'h4;
    localparam logic [3:0] OP_RESET       = 4'h5;
    localparam logic [3:0] OP_AUTOSEL     = 4'h6;
    localparam logic [3:0] OP_LOCK_SEC    = 4'h7;
    localparam logic [3:0] OP_READ_SERIAL = 4'h8;

    // device mode as tracked by the host
    typedef enum logic [3:0] {
        DEV_ARRAY   = 4'h1,
        DEV_SECURE  = 4'h2,
        DEV_QUERY   = 4'h4,
        DEV_AUTOSEL = 4'h8
    } dev_mode_t;

    localparam int          ADDR_W          = 19;
    localparam int          DATA_W          = 16;
    localparam logic [18:0] QUERY_ADDR_WORD = 19'h00055;
    localparam logic [18:0] QUERY_ADDR_BYTE = 19'h000AA;
    localparam logic [7:0]  QUERY_CMD       = 8'h98;
    localparam logic [7:0]  SEC_GROUP_ADDR  = 8'h1A;
    localparam logic [18:0] QUERY_HI_MASK   = 19'h0007F;
    localparam logic [18:0] SERIAL_BOT_WORD = 19'h00000;
    localparam logic [18:0] SERIAL_TOP_WORD = 19'h7FFF8;
    localparam logic [18:0] SERIAL_BOT_BYTE = 19'h00000;
    localparam logic [18:0] SERIAL_TOP_BYTE = 19'h0FFF0;
    localparam int          SERIAL_BYTES    = 16;
    localparam int          SECURE_BYTES    = 256;
    localparam int          LOCK_IND_POS    = 7;

    // bus cycle timing
    localparam int CLK_NS       = 20;
    localparam int STROBE_NS    = 70;
    localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;

endpackage

/* hdl/nor_bus_cycle.sv */
`timescale 1ns/1ns
module nor_bus_cycle
    import nor_host_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              start,
    input  wire logic              is_write,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic                   done,
    output logic [DATA_W-1:0]      rdata,
    output logic [ADDR_W-1:0]      flash_addr,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe,
    output logic                   ce_n,
    output logic                   oe_n,
    output logic                   we_n
);
    typedef enum logic [3:0] {
        C_IDLE   = 4'h1,
        C_SETUP  = 4'h2,
        C_STROBE = 4'h4,
        C_HOLD   = 4'h8
    } cyc_state_t;

    cyc_state_t st_reg;
    logic [3:0] cnt_reg;
    logic       wr_reg;
    wire        strobe_end = (cnt_reg == 4'(STROBE_CYC - 1));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg     <= C_IDLE;
            cnt_reg    <= 4'h0;
            wr_reg     <= 1'b0;
            done       <= 1'b0;
            rdata      <= 16'h0000;
            flash_addr <= 19'h00000;
            dq_out     <= 16'h0000;
            dq_oe      <= 1'b0;
            ce_n       <= 1'b1;
            oe_n       <= 1'b1;
            we_n       <= 1'b1;
        end else begin
            done <= 1'b0;
            case (st_reg)
                C_IDLE: if (start) begin
                    flash_addr <= addr;
                    dq_out     <= wdata;
                    wr_reg     <= is_write;
                    dq_oe      <= is_write;
                    ce_n       <= 1'b0;
                    st_reg     <= C_SETUP;
                end
                C_SETUP: begin
                    // address and data settle one cycle before the strobe
                    we_n    <= ~wr_reg;
                    oe_n    <= wr_reg;
                    cnt_reg <= 4'h0;
                    st_reg  <= C_STROBE;
                end
                C_STROBE: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (strobe_end) begin
                        if (!wr_reg) begin
                            rdata <= dq_in;
                        end
                        we_n   <= 1'b1;
                        oe_n   <= 1'b1;
                        st_reg <= C_HOLD;
                    end
                end
                C_HOLD: begin
                    // data held through the rising strobe edge
                    ce_n   <= 1'b1;
                    dq_oe  <= 1'b0;
                    done   <= 1'b1;
                    st_reg <= C_IDLE;
                end
                default: st_reg <= C_IDLE;
            endcase
        end
    end
endmodule

/* hdl/nor_mode_host.sv */
`timescale 1ns/1ns
module nor_mode_host
    import nor_host_pkg::*;
#(
    parameter bit         TOP_BOOT    = 1'b0,
    parameter logic [7:0] UNLOCK1     = 8'hAA,
    parameter logic [7:0] UNLOCK2     = 8'h55,
    parameter logic [7:0] PROG_CMD    = 8'hA0,
    parameter logic [7:0] ENTER_CMD   = 8'h88,
    parameter logic [7:0] EXIT_CMD    = 8'h90,
    parameter logic [7:0] AUTOSEL_CMD = 8'h90,
    parameter logic [7:0] RESET_CMD   = 8'hF0,
    parameter logic [7:0] PROT_CMD    = 8'h60,
    parameter logic [7:0] PROT_VERIFY = 8'h40
)(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              cmd_valid,
    input  wire logic [3:0]        cmd_op,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [DATA_W-1:0] cmd_wdata,
    input  wire logic              byte_mode,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic                   cmd_ready,
    output logic                   rsp_valid,
    output logic                   rsp_err,
    output logic [DATA_W-1:0]      rsp_data,
    output logic [3:0]             dev_mode,
    output logic                   lock_indicator_bit,
    output logic                   secure_locked,
    output logic                   vid_req,
    output logic [ADDR_W-1:0]      flash_addr,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe,
    output logic                   ce_n,
    output logic                   oe_n,
    output logic                   we_n,
    output logic                   byte_n
);
    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_ISSUE = 4'h2,
        M_WAIT = 4'h4,
        M_DONE = 4'h8
    } main_state_t;

    main_state_t        st_reg;
    dev_mode_t          mode_reg;
    logic               from_autosel_reg;
    logic [3:0]         op_reg;
    logic [ADDR_W-1:0]  addr_reg;
    logic [DATA_W-1:0]  wdata_reg;
    logic [3:0]         step_reg;
    logic               start_reg;
    logic               cyc_done;
    logic [DATA_W-1:0]  cyc_rdata;

    // unlock addresses follow the bus width
    wire [ADDR_W-1:0] u_a1 = byte_mode ? 19'h00AAA : 19'h00555;
    wire [ADDR_W-1:0] u_a2 = byte_mode ? 19'h00555 : 19'h002AA;
    wire [ADDR_W-1:0] q_a  = byte_mode ? QUERY_ADDR_BYTE : QUERY_ADDR_WORD;
    wire [ADDR_W-1:0] grp_a = {11'h000, SEC_GROUP_ADDR};
    wire [ADDR_W-1:0] ser_base = TOP_BOOT ? (byte_mode ? SERIAL_TOP_BYTE : SERIAL_TOP_WORD)
                                          : (byte_mode ? SERIAL_BOT_BYTE : SERIAL_BOT_WORD);
    wire [ADDR_W-1:0] ser_off = byte_mode ? {15'h0000, addr_reg[3:0]}
                                          : {16'h0000, addr_reg[2:0]};
    wire [ADDR_W-1:0] ser_a = ser_base + ser_off;
    // query table sits low; high word-mode bits are forced to zero
    wire [ADDR_W-1:0] rd_a = (mode_reg == DEV_QUERY && !byte_mode)
                             ? (addr_reg & QUERY_HI_MASK) : addr_reg;

    // one bus cycle per step: write flag, address, data, last step
    logic              s_wr;
    logic [ADDR_W-1:0] s_addr;
    logic [7:0]        s_data;
    logic              s_last;
    logic              s_vid;

    always_comb begin
        s_wr   = 1'b1;
        s_addr = u_a1;
        s_data = UNLOCK1;
        s_last = 1'b0;
        s_vid  = 1'b0;
        case (op_reg)
            OP_READ: begin
                s_wr   = 1'b0;
                s_addr = rd_a;
                s_last = 1'b1;
            end
            OP_READ_SERIAL: begin
                s_wr   = 1'b0;
                s_addr = ser_a;
                s_last = 1'b1;
            end
            OP_QUERY: begin
                s_addr = q_a;
                s_data = QUERY_CMD;
                s_last = 1'b1;
            end
            OP_RESET: begin
                s_addr = 19'h00000;
                s_data = RESET_CMD;
                s_last = 1'b1;
            end
            OP_PROGRAM, OP_ENTER_SEC, OP_EXIT_SEC, OP_AUTOSEL: begin
                case (step_reg)
                    4'h0: s_data = UNLOCK1;
                    4'h1: begin
                        s_addr = u_a2;
                        s_data = UNLOCK2;
                    end
                    4'h2: begin
                        s_data = (op_reg == OP_PROGRAM)   ? PROG_CMD :
                                 (op_reg == OP_ENTER_SEC) ? ENTER_CMD :
                                 (op_reg == OP_EXIT_SEC)  ? EXIT_CMD : AUTOSEL_CMD;
                        s_last = (op_reg == OP_ENTER_SEC) || (op_reg == OP_AUTOSEL);
                    end
                    default: begin
                        // full program sequence each time, never the bypass form
                        s_addr = (op_reg == OP_PROGRAM) ? addr_reg : 19'h00000;
                        s_data = (op_reg == OP_PROGRAM) ? wdata_reg[7:0] : 8'h00;
                        s_last = 1'b1;
                    end
                endcase
            end
            OP_LOCK_SEC: begin
                case (step_reg)
                    4'h0, 4'h7: s_data = UNLOCK1;
                    4'h1, 4'h8: begin
                        s_addr = u_a2;
                        s_data = UNLOCK2;
                    end
                    4'h2: s_data = ENTER_CMD;
                    4'h3: begin
                        s_addr = grp_a;
                        s_data = PROT_CMD;
                        s_vid  = 1'b1;
                    end
                    4'h4: begin
                        s_addr = grp_a;
                        s_data = PROT_VERIFY;
                        s_vid  = 1'b1;
                    end
                    4'h5: begin
                        s_wr   = 1'b0;
                        s_addr = grp_a;
                        s_vid  = 1'b1;
                    end
                    4'h6: begin
                        // let the high voltage fall before the exit sequence
                        s_wr   = 1'b0;
                        s_addr = grp_a;
                    end
                    4'h9: begin
                        s_data = EXIT_CMD;
                    end
                    default: begin
                        s_addr = 19'h00000;
                        s_data = 8'h00;
                        s_last = 1'b1;
                    end
                endcase
            end
            default: s_last = 1'b1;
        endcase
    end

    // refusals: checked once when the request is taken
    wire prot_block = lock_indicator_bit || secure_locked;
    wire refuse = ((cmd_op == OP_PROGRAM) && (mode_reg == DEV_SECURE) && prot_block)
               || ((cmd_op == OP_LOCK_SEC) && prot_block)
               || ((cmd_op == OP_QUERY) && (mode_reg != DEV_ARRAY)
                                        && (mode_reg != DEV_AUTOSEL))
               || ((cmd_op == OP_READ_SERIAL) && (mode_reg != DEV_SECURE))
               || (cmd_op > OP_READ_SERIAL);

    wire take = cmd_valid && cmd_ready;
    // indicator read from the identifier mode at the indicator location
    wire ind_read = (op_reg == OP_READ) && (mode_reg == DEV_AUTOSEL)
                 && (addr_reg[1:0] == 2'b11);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg    <= M_IDLE;
            op_reg    <= OP_READ;
            addr_reg  <= 19'h00000;
            wdata_reg <= 16'h0000;
            step_reg  <= 4'h0;
            start_reg <= 1'b0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_err   <= 1'b0;
            rsp_data  <= 16'h0000;
            vid_req   <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            rsp_valid <= 1'b0;
            case (st_reg)
                M_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (take) begin
                        cmd_ready <= 1'b0;
                        op_reg    <= cmd_op;
                        addr_reg  <= cmd_addr;
                        wdata_reg <= cmd_wdata;
                        step_reg  <= 4'h0;
                        rsp_err   <= refuse;
                        st_reg    <= refuse ? M_DONE : M_ISSUE;
                    end
                end
                M_ISSUE: begin
                    start_reg <= 1'b1;
                    vid_req   <= s_vid;
                    st_reg    <= M_WAIT;
                end
                M_WAIT: if (cyc_done) begin
                    if (!s_wr) begin
                        rsp_data <= cyc_rdata;
                    end
                    step_reg <= step_reg + 4'h1;
                    st_reg   <= s_last ? M_DONE : M_ISSUE;
                end
                M_DONE: begin
                    rsp_valid <= 1'b1;
                    cmd_ready <= 1'b1;
                    st_reg    <= M_IDLE;
                end
                default: st_reg <= M_IDLE;
            endcase
        end
    end

    // device mode tracking, updated when a sequence completes
    wire fin = (st_reg == M_DONE) && !rsp_err;
    wire ver_ok = (op_reg == OP_LOCK_SEC) && (st_reg == M_WAIT) && cyc_done
               && (step_reg == 4'h5) && cyc_rdata[0];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg           <= DEV_ARRAY;
            from_autosel_reg   <= 1'b0;
            lock_indicator_bit <= 1'b0;
            secure_locked      <= 1'b0;
            dev_mode           <= 4'(DEV_ARRAY);
            byte_n             <= 1'b1;
        end else begin
            byte_n   <= ~byte_mode;
            dev_mode <= 4'(mode_reg);
            if (ver_ok) begin
                secure_locked <= 1'b1;
            end
            if (fin && ind_read) begin
                lock_indicator_bit <= rsp_data[LOCK_IND_POS];
            end
            if (fin) begin
                case (op_reg)
                    OP_ENTER_SEC: mode_reg <= DEV_SECURE;
                    OP_EXIT_SEC, OP_LOCK_SEC: mode_reg <= DEV_ARRAY;
                    OP_AUTOSEL: mode_reg <= DEV_AUTOSEL;
                    OP_QUERY: begin
                        from_autosel_reg <= (mode_reg == DEV_AUTOSEL);
                        mode_reg         <= DEV_QUERY;
                    end
                    OP_RESET: begin
                        mode_reg <= (mode_reg == DEV_QUERY && from_autosel_reg)
                                    ? DEV_AUTOSEL : DEV_ARRAY;
                        from_autosel_reg <= 1'b0;
                    end
                    default: mode_reg <= mode_reg;
                endcase
            end
        end
    end

    nor_bus_cycle u_cycle (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .start      (start_reg),
        .is_write   (s_wr),
        .addr       (s_addr),
        .wdata      ({8'h00, s_data} | (op_reg == OP_PROGRAM && step_reg == 4'h3
                                        ? wdata_reg : 16'h0000)),
        .dq_in      (dq_in),
        .done       (cyc_done),
        .rdata      (cyc_rdata),
        .flash_addr (flash_addr),
        .dq_out     (dq_out),
        .dq_oe      (dq_oe),
        .ce_n       (ce_n),
        .oe_n       (oe_n),
        .we_n       (we_n)
    );
endmodule

/* test/nor_mode_host_checker.sv */
`timescale 1ns/1ns
module nor_mode_host_checker
    import nor_host_pkg::*;
(
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              cmd_valid,
    input wire logic [3:0]        cmd_op,
    input wire logic              cmd_ready,
    input wire logic              rsp_valid,
    input wire logic              rsp_err,
    input wire logic [3:0]        dev_mode,
    input wire logic              secure_locked,
    input wire logic              lock_indicator_bit,
    input wire logic              vid_req,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic              dq_oe,
    input wire logic              ce_n,
    input wire logic              oe_n,
    input wire logic              we_n,
    input wire logic              byte_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
        else $error("ready still high after a take");
    a_answer_ready: assert property (rsp_valid |-> cmd_ready)
        else $error("answer given while busy");
    a_err_pulse: assert property (rsp_err && !cmd_ready |=> rsp_valid)
        else $error("error flag without answer");
    a_query_refused: assert property (cmd_valid && cmd_ready && cmd_op == OP_QUERY
        && dev_mode == DEV_SECURE |-> ##2 rsp_valid && rsp_err)
        else $error("query in secure mode not refused");
    a_lock_refuse: assert property (cmd_valid && cmd_ready && cmd_op == OP_PROGRAM
        && dev_mode == DEV_SECURE && (lock_indicator_bit || secure_locked)
        |-> ce_n [*3] ##0 (rsp_valid && rsp_err))
        else $error("program into protected region reached the bus");
    a_locked_sticky: assert property (secure_locked |=> secure_locked)
        else $error("lock state dropped");
    a_query_addr: assert property (dev_mode == DEV_QUERY && !oe_n && !ce_n && byte_n
        |-> flash_addr[ADDR_W-1:7] == '0)
        else $error("query read with high address bits set");
    a_read_released: assert property (!oe_n |-> !dq_oe && we_n)
        else $error("data driven during a read");
    a_write_drives: assert property (!we_n |-> dq_oe && !ce_n && oe_n)
        else $error("write strobe without data or select");
    a_mode_onehot: assert property ($onehot(dev_mode))
        else $error("tracked mode not one-hot");
    a_vid_secure: assert property (vid_req |-> dev_mode == DEV_SECURE)
        else $error("protect voltage outside secure mode");
endmodule

bind nor_mode_host nor_mode_host_checker nor_mode_host_checker_i (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .dev_mode(dev_mode),
    .secure_locked(secure_locked), .lock_indicator_bit(lock_indicator_bit),
    .vid_req(vid_req), .flash_addr(flash_addr), .dq_oe(dq_oe), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .byte_n(byte_n)
);

/* test/nor_flash_model.sv */
`timescale 1ns/1ns
module nor_flash_model
    import nor_host_pkg::*;
(
    input  wire logic              factory,
    input  wire logic              vid_req,
    input  wire logic [ADDR_W-1:0] flash_addr,
    input  wire logic [DATA_W-1:0] dq_out,
    input  wire logic              ce_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    output logic [DATA_W-1:0]      dq_in
);
    dev_mode_t   mode = DEV_ARRAY;
    dev_mode_t   ret  = DEV_ARRAY;
    logic [1:0]  step = 2'd0;
    logic        exiting = 1'b0;
    logic        prog = 1'b0;
    logic        prot = 1'b0;
    logic [15:0] smem [128];
    logic [15:0] rd;
    logic [15:0] last = 16'h5A5A;

    // serial number sits in the first eight words, rest erased
    initial for (int i = 0; i < 128; i++) smem[i] = (i < 8) ? 16'h5E00 + 16'(i) : 16'hFFFF;

    function automatic logic [15:0] qval(input logic [7:0] a);
        case (a)
            8'h10: qval = 16'h0051;
            8'h11: qval = 16'h0052;
            8'h12: qval = 16'h0059;
            8'h13: qval = 16'h0002;
            8'h15: qval = 16'h0040;
            8'h1B: qval = 16'h0027;
            8'h1C: qval = 16'h0036;
            8'h1F: qval = 16'h0003;
            8'h21: qval = 16'h0009;
            8'h23: qval = 16'h0005;
            8'h25: qval = 16'h0004;
            default: qval = 16'h0000;
        endcase
    endfunction

    always @(posedge we_n) begin
        if (!ce_n) begin
            if (vid_req) begin
                if (dq_out[7:0] == 8'h60) prot <= 1'b1;
            end else if (prog) begin
                prog <= 1'b0;
                // protected region ignores the data, no bit ever changes
                if (mode == DEV_SECURE && !(factory || prot))
                    smem[flash_addr[6:0]] <= smem[flash_addr[6:0]] & dq_out;
            end else if (dq_out[7:0] == 8'hF0) begin
                mode <= (mode == DEV_QUERY) ? ret : DEV_ARRAY;
                step <= 2'd0;
            end else if (dq_out[7:0] == QUERY_CMD && flash_addr == QUERY_ADDR_WORD
                         && (mode == DEV_ARRAY || mode == DEV_AUTOSEL)) begin
                ret <= mode;
                mode <= DEV_QUERY;
            end else if (step == 2'd0 && dq_out[7:0] == 8'hAA && flash_addr == 19'h555) begin
                step <= 2'd1;
            end else if (step == 2'd1 && dq_out[7:0] == 8'h55 && flash_addr == 19'h2AA) begin
                step <= 2'd2;
            end else if (step == 2'd2) begin
                step <= 2'd0;
                if (dq_out[7:0] == 8'h88) mode <= DEV_SECURE;
                if (dq_out[7:0] == 8'h90 && mode == DEV_SECURE) exiting <= 1'b1;
                if (dq_out[7:0] == 8'h90 && mode != DEV_SECURE) mode <= DEV_AUTOSEL;
                // no bypass mode exists here, only the full sequence programs
                if (dq_out[7:0] == 8'hA0) prog <= 1'b1;
            end else if (exiting && dq_out[7:0] == 8'h00) begin
                exiting <= 1'b0;
                mode <= DEV_ARRAY;
            end else begin
                step <= 2'd0;
            end
        end
    end

    always_comb begin
        if (vid_req) rd = {15'h0, factory | prot};
        else if (mode == DEV_QUERY)
            rd = (flash_addr[18:7] != 12'h000) ? 16'hDEAD : qval(flash_addr[7:0]);
        else if (mode == DEV_SECURE) rd = smem[flash_addr[6:0]];
        else if (mode == DEV_AUTOSEL)
            rd = (flash_addr[1:0] == 2'b11) ? {8'h00, factory, 7'h16} : 16'h0000;
        else rd = flash_addr[15:0] ^ 16'hA5A5;
    end

    // released bus shows the inverse of the last word, not a stale copy
    always @(posedge oe_n) last <= rd;
    assign dq_in = (!ce_n && !oe_n) ? rd : ~last;
endmodule

/* test/nor_mode_host_tb_top.sv */
`timescale 1ns/1ns
module nor_mode_host_tb_top;
    import nor_host_pkg::*;
    logic              clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic              cmd_valid = 1'b0;
    logic [3:0]        cmd_op = OP_READ;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [DATA_W-1:0] cmd_wdata = '0;
    logic              byte_mode = 1'b0;
    logic              factory = 1'b0;
    logic [DATA_W-1:0] dq_in, rsp_data, dq_out;
    logic [ADDR_W-1:0] flash_addr;
    logic [3:0]        dev_mode;
    logic              cmd_ready, rsp_valid, rsp_err, lock_indicator_bit, secure_locked;
    logic              vid_req, dq_oe, ce_n, oe_n, we_n, byte_n;
    int                bad_count = 0;
    int                n_tests = 0;
    int                cycles = 0;
    localparam logic [7:0]  QA [13] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h15, 8'h19, 8'h1B,
                                        8'h1C, 8'h1D, 8'h1F, 8'h21, 8'h23, 8'h25};
    localparam logic [15:0] QV [13] = '{16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0040,
                                        16'h0000, 16'h0027, 16'h0036, 16'h0000, 16'h0003,
                                        16'h0009, 16'h0005, 16'h0004};

    always #10 clk = ~clk;

    nor_mode_host nor_mode_host_i (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .byte_mode(byte_mode),
        .dq_in(dq_in), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
        .rsp_data(rsp_data), .dev_mode(dev_mode), .lock_indicator_bit(lock_indicator_bit),
        .secure_locked(secure_locked), .vid_req(vid_req), .flash_addr(flash_addr),
        .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .byte_n(byte_n));
    nor_flash_model nor_flash_model_i (.factory(factory), .vid_req(vid_req),
        .flash_addr(flash_addr), .dq_out(dq_out), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .dq_in(dq_in));

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one request, held until taken, then wait for its answer
    task automatic go(input logic [3:0] o, input logic [18:0] a, input logic [15:0] d,
                      input logic e_err);
        int i;
        while (cmd_ready !== 1'b1) @(negedge clk);
        cmd_op = o;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        for (i = 0; i < 300 && rsp_valid !== 1'b1; i++) @(negedge clk);
        if (i == 300) bad_count++;
        chk("rsp_err", {15'h0, rsp_err}, {15'h0, e_err});
    endtask

    task automatic rd(input logic [18:0] a, input logic [15:0] exp);
        go(OP_READ, a, 16'h0000, 1'b0);
        chk("rsp_data", rsp_data, exp);
    endtask

    task automatic mode_is(input dev_mode_t m);
        @(negedge clk);
        chk("dev_mode", {12'h000, dev_mode}, {12'h000, m});
    endtask

    task automatic t_query();
        int k;
        go(OP_QUERY, QUERY_ADDR_WORD, 16'h0000, 1'b0);
        mode_is(DEV_QUERY);
        for (k = 0; k < 13; k++) rd({11'h000, QA[k]}, QV[k]);
        rd(19'h40012, 16'h0059);
        go(OP_RESET, 19'h00000, 16'h0000, 1'b0);
        mode_is(DEV_ARRAY);
        rd(19'h00123, 16'h0123 ^ 16'hA5A5);
    endtask

    task automatic t_ident_query();
        go(OP_AUTOSEL, 19'h00000, 16'h0000, 1'b0);
        go(OP_QUERY, QUERY_ADDR_WORD, 16'h0000, 1'b0);
        rd(19'h00010, 16'h0051);
        go(OP_RESET, 19'h00000, 16'h0000, 1'b0);
        mode_is(DEV_AUTOSEL);
        go(OP_RESET, 19'h00000, 16'h0000, 1'b0);
        mode_is(DEV_ARRAY);
    endtask

    task automatic t_factory();
        factory = 1'b1;
        go(OP_AUTOSEL, 19'h00000, 16'h0000, 1'b0);
        rd(19'h00003, 16'h0096);
        chk("lock_indicator_bit", {15'h0, lock_indicator_bit}, 16'h0001);
        go(OP_RESET, 19'h00000, 16'h0000, 1'b0);
        go(OP_READ_SERIAL, 19'h00000, 16'h0000, 1'b1);
        go(OP_ENTER_SEC, 19'h00000, 16'h0000, 1'b0);
        mode_is(DEV_SECURE);
        go(OP_READ_SERIAL, 19'h00000, 16'h0000, 1'b0);
        chk("serial", rsp_data, 16'h5E00);
        rd(19'h00007, 16'h5E07);
        go(OP_QUERY, QUERY_ADDR_WORD, 16'h0000, 1'b1);
        go(OP_PROGRAM, 19'h00000, 16'h0000, 1'b1);
        go(OP_LOCK_SEC, 19'h00000, 16'h0000, 1'b1);
        rd(19'h00000, 16'h5E00);
        go(OP_EXIT_SEC, 19'h00000, 16'h0000, 1'b0);
        mode_is(DEV_ARRAY);
    endtask

    task automatic t_customer();
        factory = 1'b0;
        go(OP_AUTOSEL, 19'h00000, 16'h0000, 1'b0);
        rd(19'h00003, 16'h0016);
        chk("lock_indicator_bit", {15'h0, lock_indicator_bit}, 16'h0000);
        go(OP_RESET, 19'h00000, 16'h0000, 1'b0);
        go(OP_ENTER_SEC, 19'h00000, 16'h0000, 1'b0);
        go(OP_PROGRAM, 19'h00020, 16'h1234, 1'b0);
        rd(19'h00020, 16'h1234);
        go(OP_LOCK_SEC, 19'h00000, 16'h0000, 1'b0);
        chk("secure_locked", {15'h0, secure_locked}, 16'h0001);
        mode_is(DEV_ARRAY);
        go(OP_ENTER_SEC, 19'h00000, 16'h0000, 1'b0);
        go(OP_PROGRAM, 19'h00020, 16'h0000, 1'b1);
        rd(19'h00020, 16'h1234);
        go(OP_EXIT_SEC, 19'h00000, 16'h0000, 1'b0);
    endtask

    // generous ceiling: 45 requests of at most about a hundred cycles each
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        mode_is(DEV_ARRAY);
        t_query();
        t_ident_query();
        t_factory();
        t_customer();
        close_out();
    end
endmodule
